// file: design/uart_irq_cfg.svh
// register map, field positions and fixed codes of the interrupt and fifo control block
`ifndef UART_IRQ_CFG_SVH
`define UART_IRQ_CFG_SVH
`define RA_HOLD 3'h0
`define RA_MASK 3'h1
`define RA_SRC 3'h2
`define RA_FIFO 3'h2
`define RA_LINE 3'h5
`define RA_MODEM 3'h6
`define MB_RX 0
`define MB_TX 1
`define MB_LINE 2
`define MB_MODEM 3
`define MB_SLEEP 4
`define MB_XOFF 5
`define MB_RTS 6
`define MB_CTS 7
`define FB_EN 0
`define FB_RXFL 1
`define FB_TXFL 2
`define FB_WAKE 3
`define MASK_RST 8'h00
`define SEL_RST 2'h0
`define CODE_LINE 6'h06
`define CODE_TMO 6'h0c
`define CODE_RX 6'h04
`define CODE_TX 6'h02
`define CODE_MODEM 6'h00
`define CODE_CHAR 6'h10
`define CODE_FLOW 6'h20
`define CODE_NONE 6'h01
`define TX_TRIG0 6'h10
`define TX_TRIG1 6'h08
`define TX_TRIG2 6'h18
`define TX_TRIG3 6'h1e
`define RX_TRIG0 6'h08
`define RX_TRIG1 6'h10
`define RX_TRIG2 6'h18
`define RX_TRIG3 6'h1c
`define TMO_CHARS 4
`define TMO_BITS 12
`endif

// file: design/uart_irq_pkg.sv
// types shared by the interrupt and fifo control block
package uart_irq_pkg;
  typedef enum logic [7:0] {
    SRC_NONE = 8'h01,
    SRC_LINE = 8'h02,
    SRC_TMO = 8'h04,
    SRC_RX = 8'h08,
    SRC_TX = 8'h10,
    SRC_MODEM = 8'h20,
    SRC_CHAR = 8'h40,
    SRC_FLOW = 8'h80
  } src_t;
endpackage : uart_irq_pkg

// file: design/rx_timeout_timer.sv
// receive timeout timer: four character times plus twelve bit times of silence
`include "uart_irq_cfg.svh"
module rx_timeout_timer #(
  parameter int CW = 10
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic bit_tick,
  input wire logic [3:0] char_bits,
  input wire logic armed,
  input wire logic restart,
  output logic expired
);
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic exp_r, exp_nxt;
  logic [CW-1:0] limit;

  function automatic logic [CW-1:0] tmo_limit(input logic [3:0] cb);
    tmo_limit = CW'(`TMO_CHARS * cb + `TMO_BITS);
  endfunction : tmo_limit

  assign limit = tmo_limit(char_bits);
  assign expired = exp_r;

  always_comb begin
    cnt_nxt = cnt_r;
    exp_nxt = exp_r;
    if (restart || !armed) begin
      cnt_nxt = '0;
      exp_nxt = 1'b0;
    end else if (bit_tick && !exp_r) begin
      if (cnt_r + 1'b1 >= limit) begin
        exp_nxt = 1'b1;
      end
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  tmo_clear_a: assert property (clk_en && restart |=> !expired)
    else $error("timeout still set after restart");
endmodule : rx_timeout_timer

// file: design/uart_interrupt_fifo_control.sv
// interrupt masking, source priority and fifo control of the uart
// Functional notes
// - fifo rx interrupt follows count versus trigger
// - data ready set on push, cleared when empty
// - line status bits 0..4 ready, overrun, errors
// - bits 5..7 holding empty, all empty, error
// - mask bit 0 gates receive ready interrupt
// - mask bit 1 transmit ready, immediate if empty
// - line interrupt on overrun or error char
// - mask 6/7 rts/cts rising, with auto flow
// - mask 4..7 need enhanced enable; reset zero
// - status read shows highest pending, rest queue
// - fixed six-bit code per source priority
// - timeout after 4 chars plus 12 bits
// - modem, character and wakeup interrupt sources
// - line read, rx reads, tx write/read clear
// - modem read clears modem/flow; status read others
// - status bit 0 low while pending, else high; stays high while only wake is pending
// - status bits 7:6 mirror fifo enable
// - fifo bit 0 enables; others need it set
// - flush bits pulse pointer reset, self-clear
// - fifo bit 3 wake enable, needs enhanced
// - tx trigger select and below/empty firing
// - rx trigger select, one select field for both
// - tx 16,8,24,30; rx 8,16,24,28
`include "uart_irq_cfg.svh"
module uart_interrupt_fifo_control import uart_irq_pkg::*; #(
  parameter int CW = 6,
  parameter int TMR_W = 10
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [2:0] addr,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic lcr_dlab,
  input wire logic enh_en,
  input wire logic auto_rts_en,
  input wire logic auto_cts_en,
  input wire logic err_on_entry,
  input wire logic bit_tick,
  input wire logic [3:0] char_bits,
  input wire logic [7:0] rx_head_data,
  input wire logic [CW-1:0] rx_count,
  input wire logic rx_push,
  input wire logic [2:0] rx_head_err,
  input wire logic rx_any_err,
  input wire logic overrun_evt,
  input wire logic head_err_evt,
  input wire logic entry_err_evt,
  input wire logic [CW-1:0] tx_count,
  input wire logic thr_empty,
  input wire logic tx_all_empty,
  input wire logic [7:0] modem_status,
  input wire logic char_evt,
  input wire logic char_special,
  input wire logic wake_evt,
  input wire logic rts_n_out,
  input wire logic cts_n_pin,
  output logic irq,
  output logic fifo_en,
  output logic rx_flush,
  output logic tx_flush,
  output logic sleep_en,
  output logic [CW-1:0] rx_trig,
  output logic [CW-1:0] tx_trig
);
  ////////////////////////////////////////////////////////////////////////////////
  logic cts_s1_r, cts_s2_r, cts_prev_r, rts_prev_r;
  logic [7:0] mask_r, mask_nxt;
  logic fen_r, fen_nxt, wen_r, wen_nxt, rxf_r, rxf_nxt, txf_r, txf_nxt;
  logic [1:0] rsel_r, rsel_nxt, tsel_r, tsel_nxt;
  logic line_r, line_nxt, ovr_r, ovr_nxt, txi_r, txi_nxt, chr_r, chr_nxt;
  logic spc_r, spc_nxt, rtsi_r, rtsi_nxt, ctsi_r, ctsi_nxt, wk_r, wk_nxt;
  logic fill_r, fill_nxt, tcp_r, tcp_nxt, irq_r, irq_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic wr_mask, wr_fifo, wr_hold, rd_hold, rd_src, rd_line, rd_modem;
  logic p_line, p_tmo, p_rx, p_tx, p_modem, p_chr, p_flow, p_wake, any_p;
  logic tmo_exp, tx_cond, rx_ready;
  src_t top;
  logic [5:0] code;

  function automatic logic [CW-1:0] rx_level(input logic [1:0] s);
    case (s)
      2'h0: rx_level = CW'(`RX_TRIG0);
      2'h1: rx_level = CW'(`RX_TRIG1);
      2'h2: rx_level = CW'(`RX_TRIG2);
      default: rx_level = CW'(`RX_TRIG3);
    endcase
  endfunction : rx_level

  function automatic logic [CW-1:0] tx_level(input logic [1:0] s);
    case (s)
      2'h0: tx_level = CW'(`TX_TRIG0);
      2'h1: tx_level = CW'(`TX_TRIG1);
      2'h2: tx_level = CW'(`TX_TRIG2);
      default: tx_level = CW'(`TX_TRIG3);
    endcase
  endfunction : tx_level

  function automatic logic [5:0] src_code(input src_t s);
    case (s)
      SRC_LINE: src_code = `CODE_LINE;
      SRC_TMO: src_code = `CODE_TMO;
      SRC_RX: src_code = `CODE_RX;
      SRC_TX: src_code = `CODE_TX;
      SRC_MODEM: src_code = `CODE_MODEM;
      SRC_CHAR: src_code = `CODE_CHAR;
      SRC_FLOW: src_code = `CODE_FLOW;
      default: src_code = `CODE_NONE;
    endcase
  endfunction : src_code

  ////////////////////////////////////////////////////////////////////////////////
  // access decode
  assign wr_mask = wr_stb && !lcr_dlab && addr == `RA_MASK;
  assign wr_fifo = wr_stb && addr == `RA_FIFO;
  assign wr_hold = wr_stb && !lcr_dlab && addr == `RA_HOLD;
  assign rd_hold = rd_stb && !lcr_dlab && addr == `RA_HOLD;
  assign rd_src = rd_stb && addr == `RA_SRC;
  assign rd_line = rd_stb && addr == `RA_LINE;
  assign rd_modem = rd_stb && addr == `RA_MODEM;

  assign rx_trig = rx_level(rsel_r);
  assign tx_trig = tx_level(tsel_r);
  assign rx_ready = rx_count != '0;
  assign fifo_en = fen_r;
  assign rx_flush = rxf_r;
  assign tx_flush = txf_r;
  assign sleep_en = enh_en && mask_r[`MB_SLEEP];
  assign irq = irq_r;
  assign rdata = rd_r;

  rx_timeout_timer #(
    .CW(TMR_W)
  ) u_tmo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .bit_tick(bit_tick),
    .char_bits(char_bits),
    .armed(fen_r && rx_ready),
    .restart(rx_push || rd_hold),
    .expired(tmo_exp)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // pending sources and priority
  always_comb begin
    tx_cond = thr_empty;
    if (fen_r) begin
      tx_cond = fill_r ? (tx_count < tx_trig) : (tx_count == '0);
    end
    p_line = mask_r[`MB_LINE] && line_r;
    p_tmo = mask_r[`MB_RX] && fen_r && tmo_exp;
    p_rx = mask_r[`MB_RX] && (fen_r ? rx_count >= rx_trig : rx_ready);
    p_tx = mask_r[`MB_TX] && txi_r;
    p_modem = mask_r[`MB_MODEM] && (|modem_status[3:0]);
    p_chr = enh_en && mask_r[`MB_XOFF] && chr_r;
    p_flow = enh_en && ((mask_r[`MB_RTS] && auto_rts_en && rtsi_r) ||
             (mask_r[`MB_CTS] && auto_cts_en && ctsi_r));
    p_wake = enh_en && wen_r && wk_r;
    any_p = p_line || p_tmo || p_rx || p_tx || p_modem || p_chr || p_flow || p_wake;
    if (p_line) top = SRC_LINE;
    else if (p_tmo) top = SRC_TMO;
    else if (p_rx) top = SRC_RX;
    else if (p_tx) top = SRC_TX;
    else if (p_modem) top = SRC_MODEM;
    else if (p_chr) top = SRC_CHAR;
    else if (p_flow) top = SRC_FLOW;
    else top = SRC_NONE;
    code = src_code(top);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers
  always_comb begin
    mask_nxt = mask_r;
    fen_nxt = fen_r;
    wen_nxt = wen_r;
    rsel_nxt = rsel_r;
    tsel_nxt = tsel_r;
    rxf_nxt = 1'b0;
    txf_nxt = 1'b0;
    if (wr_mask) mask_nxt = wdata;
    if (wr_fifo) begin
      fen_nxt = wdata[`FB_EN];
      if (wdata[`FB_EN]) begin
        rxf_nxt = wdata[`FB_RXFL];
        txf_nxt = wdata[`FB_TXFL];
        rsel_nxt = wdata[7:6];
        tsel_nxt = wdata[7:6];
        if (enh_en) begin
          wen_nxt = wdata[`FB_WAKE];
          tsel_nxt = wdata[5:4];
          rsel_nxt = wdata[5:4];
          if (wdata[7:6] != 2'h0) begin
            rsel_nxt = wdata[7:6];
            tsel_nxt = wdata[7:6];
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mask_r <= `MASK_RST;
      fen_r <= 1'b0;
      wen_r <= 1'b0;
      rsel_r <= `SEL_RST;
      tsel_r <= `SEL_RST;
      rxf_r <= 1'b0;
      txf_r <= 1'b0;
    end else if (clk_en) begin
      mask_r <= mask_nxt;
      fen_r <= fen_nxt;
      wen_r <= wen_nxt;
      rsel_r <= rsel_nxt;
      tsel_r <= tsel_nxt;
      rxf_r <= rxf_nxt;
      txf_r <= txf_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky sources: a set in the clearing cycle wins
  always_comb begin
    line_nxt = line_r;
    ovr_nxt = ovr_r;
    txi_nxt = txi_r;
    chr_nxt = chr_r;
    spc_nxt = spc_r;
    rtsi_nxt = rtsi_r;
    ctsi_nxt = ctsi_r;
    wk_nxt = wk_r;
    fill_nxt = fill_r;
    if (tx_count > tx_trig) fill_nxt = 1'b1;
    else if (tx_count == '0) fill_nxt = 1'b0;
    tcp_nxt = tx_cond;
    if (rd_line) begin
      line_nxt = 1'b0;
      ovr_nxt = 1'b0;
    end
    if (wr_hold || (rd_src && top == SRC_TX)) txi_nxt = 1'b0;
    if ((rd_src && top == SRC_CHAR) || (rx_push && spc_r)) chr_nxt = 1'b0;
    if (rd_modem) begin
      rtsi_nxt = 1'b0;
      ctsi_nxt = 1'b0;
    end
    if (rd_src && top == SRC_NONE) wk_nxt = 1'b0;
    if (overrun_evt) begin
      line_nxt = 1'b1;
      ovr_nxt = 1'b1;
    end
    if (err_on_entry ? entry_err_evt : head_err_evt) line_nxt = 1'b1;
    if ((tx_cond && !tcp_r) ||
        (wr_mask && wdata[`MB_TX] && !mask_r[`MB_TX] && tx_cond)) begin
      txi_nxt = 1'b1;
    end
    if (char_evt) begin
      chr_nxt = 1'b1;
      spc_nxt = char_special;
    end
    if (rts_n_out && !rts_prev_r) rtsi_nxt = 1'b1;
    if (cts_s2_r && !cts_prev_r) ctsi_nxt = 1'b1;
    if (wake_evt) wk_nxt = 1'b1;
    irq_nxt = any_p;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      line_r <= 1'b0;
      ovr_r <= 1'b0;
      txi_r <= 1'b0;
      chr_r <= 1'b0;
      spc_r <= 1'b0;
      rtsi_r <= 1'b0;
      ctsi_r <= 1'b0;
      wk_r <= 1'b0;
      fill_r <= 1'b0;
      tcp_r <= 1'b1;
      irq_r <= 1'b0;
      cts_s1_r <= 1'b1;
      cts_s2_r <= 1'b1;
      cts_prev_r <= 1'b1;
      rts_prev_r <= 1'b1;
    end else if (clk_en) begin
      line_r <= line_nxt;
      ovr_r <= ovr_nxt;
      txi_r <= txi_nxt;
      chr_r <= chr_nxt;
      spc_r <= spc_nxt;
      rtsi_r <= rtsi_nxt;
      ctsi_r <= ctsi_nxt;
      wk_r <= wk_nxt;
      fill_r <= fill_nxt;
      tcp_r <= tcp_nxt;
      irq_r <= irq_nxt;
      cts_s1_r <= cts_n_pin;
      cts_s2_r <= cts_s1_r;
      cts_prev_r <= cts_s2_r;
      rts_prev_r <= rts_n_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data
  always_comb begin
    rd_nxt = rd_r;
    if (rd_stb) begin
      case (addr)
        `RA_HOLD: rd_nxt = lcr_dlab ? 8'h00 : rx_head_data;
        `RA_MASK: rd_nxt = lcr_dlab ? 8'h00 : mask_r;
        `RA_SRC: rd_nxt = {fen_r, fen_r, code};
        `RA_LINE: rd_nxt = {rx_any_err, tx_all_empty, thr_empty, rx_head_err,
                            ovr_r, rx_ready};
        `RA_MODEM: rd_nxt = modem_status;
        default: rd_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rd_r <= 8'h00;
    end else if (clk_en) begin
      rd_r <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_flush_rx;
    rx_flush ##1 !rx_flush;
  endsequence

  rx_level_irq_a: assert property (
    clk_en && mask_r[`MB_RX] && fen_r && rx_count >= rx_trig |=> irq)
    else $error("rx trigger reached without irq");
  ready_bit_a: assert property (
    clk_en && rd_line |=> rdata[0] == $past(rx_ready))
    else $error("data ready bit wrong");
  mask_reset_a: assert property ($rose(rstn) |-> mask_r == `MASK_RST)
    else $error("mask not cleared by reset");
  tx_enable_a: assert property (
    clk_en && wr_mask && wdata[`MB_TX] && !mask_r[`MB_TX] && tx_cond |=> txi_r && irq_nxt)
    else $error("tx ready not raised on enable");
  line_first_a: assert property (p_line |-> code == `CODE_LINE)
    else $error("line status not top priority");
  pend_bit_a: assert property (
    clk_en && rd_src && any_p && !p_wake |=> !rdata[0])
    else $error("pending bit reads high");
  fifo_bits_a: assert property (
    clk_en && rd_src |=> rdata[7:6] == {2{$past(fen_r)}})
    else $error("fifo status bits wrong");
  fcr_ignore_a: assert property (
    clk_en && wr_fifo && !wdata[`FB_EN] |=> !fen_r && $stable(rsel_r) && !rx_flush)
    else $error("fifo write without enable took effect");
  flush_pulse_a: assert property (
    wr_fifo && wdata[0] && wdata[1] && clk_en ##1 clk_en && !rxf_nxt |-> s_flush_rx)
    else $error("rx flush not a single pulse");
  line_clear_a: assert property (
    clk_en && rd_line && !overrun_evt && !entry_err_evt && !head_err_evt |=> !line_r)
    else $error("line interrupt not cleared by read");
endmodule : uart_interrupt_fifo_control

// file: testbench/host_bus_model.sv
// host processor model driving the register port of the interrupt and fifo control block
module host_bus_model (
  input wire logic ref_clk,
  input wire logic [7:0] rdata,
  output logic [2:0] addr,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr = 3'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one write: strobe for one taken edge, then released lines show the inverse
  task bus_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : bus_write
  // one read: data is registered at the taking edge and held until the next read
  task bus_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    @(posedge ref_clk);
    #1;
    d = rdata;
  endtask : bus_read
  // a fifo control write that must program its other bits carries bit 0 set
  task fifo_write(input logic [7:0] d);
    bus_write(3'h2, d | 8'h01);
  endtask : fifo_write
endmodule : host_bus_model

// file: testbench/test_uart_interrupt_fifo_control.sv
// self-checking bench of the interrupt and fifo control block
`include "uart_irq_cfg.svh"
module test_uart_interrupt_fifo_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en, lcr_dlab, enh_en, auto_rts_en, auto_cts_en, err_on_entry, bit_tick;
  logic rx_push, rx_any_err, overrun_evt, head_err_evt, entry_err_evt, thr_empty;
  logic tx_all_empty, char_evt, char_special, wake_evt, rts_n_out, cts_n_pin;
  logic wr_stb, rd_stb, irq, fifo_en, rx_flush, tx_flush, sleep_en;
  logic [3:0] char_bits;
  logic [2:0] addr, rx_head_err;
  logic [7:0] rx_head_data, modem_status, wdata, rdata, rv;
  logic [5:0] rx_count, tx_count, rx_trig, tx_trig;
  logic [5:0] txt [4] = '{6'd16, 6'd8, 6'd24, 6'd30};
  logic [5:0] rxt [4] = '{6'd8, 6'd16, 6'd24, 6'd28};
  int bad_count = 0;
  int n_tests = 0;
  int rxf_n = 0;
  int txf_n = 0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (rx_flush === 1'b1) rxf_n++;
    if (tx_flush === 1'b1) txf_n++;
  end
  uart_interrupt_fifo_control dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
    .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .wdata(wdata), .rdata(rdata),
    .lcr_dlab(lcr_dlab), .enh_en(enh_en), .auto_rts_en(auto_rts_en),
    .auto_cts_en(auto_cts_en), .err_on_entry(err_on_entry), .bit_tick(bit_tick),
    .char_bits(char_bits), .rx_head_data(rx_head_data), .rx_count(rx_count),
    .rx_push(rx_push), .rx_head_err(rx_head_err), .rx_any_err(rx_any_err),
    .overrun_evt(overrun_evt), .head_err_evt(head_err_evt), .entry_err_evt(entry_err_evt),
    .tx_count(tx_count), .thr_empty(thr_empty), .tx_all_empty(tx_all_empty),
    .modem_status(modem_status), .char_evt(char_evt), .char_special(char_special),
    .wake_evt(wake_evt), .rts_n_out(rts_n_out), .cts_n_pin(cts_n_pin), .irq(irq),
    .fifo_en(fifo_en), .rx_flush(rx_flush), .tx_flush(tx_flush), .sleep_en(sleep_en),
    .rx_trig(rx_trig), .tx_trig(tx_trig));
  host_bus_model u_host (.ref_clk(ref_clk), .rdata(rdata), .addr(addr), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .wdata(wdata));
  ////////////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk8
  task chk1(input string nm, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk1
  task rd_chk(input logic [2:0] a, input logic [7:0] exp, input string nm);
    u_host.bus_read(a, rv);
    chk8(nm, exp, rv);
  endtask : rd_chk
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task wait_irq(input logic exp, input int lim);
    int i;
    i = 0;
    #1;
    while (irq !== exp && i < lim) begin
      cyc(1);
      i++;
    end
    chk1("irq", exp, irq);
    if (irq !== exp) final_report();
  endtask : wait_irq
  task pulse(input int k);
    @(posedge ref_clk);
    if (k == 0) overrun_evt <= 1'b1;
    if (k == 1) char_evt <= 1'b1;
    if (k == 2) rx_push <= 1'b1;
    if (k == 3) head_err_evt <= 1'b1;
    if (k == 4) entry_err_evt <= 1'b1;
    if (k == 5) wake_evt <= 1'b1;
    @(posedge ref_clk);
    overrun_evt <= 1'b0;
    char_evt <= 1'b0;
    rx_push <= 1'b0;
    {head_err_evt, entry_err_evt, wake_evt} <= 3'h0;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {lcr_dlab, enh_en, auto_rts_en, auto_cts_en, err_on_entry, bit_tick} = 6'h00;
    {rx_push, rx_any_err, overrun_evt, head_err_evt, entry_err_evt} = 5'h00;
    {char_evt, char_special, wake_evt, cts_n_pin} = 4'h0;
    {clk_en, thr_empty, tx_all_empty, rts_n_out} = 4'hf;
    char_bits = 4'ha;
    rx_head_err = 3'h0;
    rx_head_data = 8'h5a;
    modem_status = 8'h00;
    rx_count = 6'h00;
    tx_count = 6'h00;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    rd_chk(`RA_SRC, 8'h01, "source");
    chk1("irq", 1'b0, irq);
    chk8("rx_trig", 8'd8, {2'b00, rx_trig});
    chk8("tx_trig", 8'd16, {2'b00, tx_trig});
    rd_chk(`RA_MASK, 8'h00, "mask");
    u_host.bus_write(`RA_MASK, 8'h02);
    wait_irq(1'b1, 3);
    rd_chk(`RA_SRC, {2'b00, `CODE_TX}, "source");
    wait_irq(1'b0, 3);
    rd_chk(`RA_SRC, 8'h01, "source");
    u_host.bus_write(`RA_MASK, 8'h00);
    u_host.fifo_write(8'h03);
    cyc(2);
    chk1("fifo_en", 1'b1, fifo_en);
    chk8("rx flushes", 8'd1, rxf_n[7:0]);
    chk8("tx flushes", 8'd0, txf_n[7:0]);
    rd_chk(`RA_SRC, 8'hc1, "source");
    u_host.bus_write(`RA_FIFO, 8'h06);
    rd_chk(`RA_SRC, 8'h01, "source");
    chk8("rx flushes", 8'd1, rxf_n[7:0]);
    u_host.fifo_write(8'h07);
    cyc(2);
    chk8("both flushes", 8'h12, {txf_n[3:0], rxf_n[3:0]});
    enh_en <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      u_host.fifo_write({2'b00, k[1:0], 4'h1});
      cyc(1);
      chk8("tx_trig", {2'b00, txt[k]}, {2'b00, tx_trig});
      chk8("rx_trig", {2'b00, rxt[k]}, {2'b00, rx_trig});
      u_host.fifo_write({k[1:0], 6'h31});
      cyc(1);
      chk8("rx_trig", {2'b00, rxt[k > 0 ? k : 3]}, {2'b00, rx_trig});
      chk8("tx_trig", {2'b00, txt[k > 0 ? k : 3]}, {2'b00, tx_trig});
    end
    enh_en <= 1'b0;
    u_host.fifo_write(8'h01);
    u_host.fifo_write(8'h31);
    cyc(1);
    chk8("tx_trig", 8'd16, {2'b00, tx_trig});
    rx_count <= 6'd7;
    u_host.bus_write(`RA_MASK, 8'h01);
    cyc(3);
    chk1("irq", 1'b0, irq);
    rx_count <= 6'd8;
    wait_irq(1'b1, 3);
    rd_chk(`RA_SRC, {2'b11, `CODE_RX}, "source");
    rx_count <= 6'd7;
    wait_irq(1'b0, 3);
    rx_count <= 6'd8;
    rx_head_err <= 3'h5;
    rx_any_err <= 1'b1;
    u_host.bus_write(`RA_MASK, 8'h05);
    pulse(0);
    cyc(2);
    rd_chk(`RA_SRC, {2'b11, `CODE_LINE}, "source");
    rd_chk(`RA_LINE, 8'hf7, "line");
    rd_chk(`RA_SRC, {2'b11, `CODE_RX}, "source");
    {rx_count, rx_head_err, rx_any_err, tx_all_empty} <= 11'h000;
    rd_chk(`RA_LINE, 8'h20, "line");
    tx_all_empty <= 1'b1;
    u_host.bus_write(`RA_MASK, 8'h08);
    modem_status <= 8'h01;
    wait_irq(1'b1, 3);
    rd_chk(`RA_SRC, {2'b11, `CODE_MODEM}, "source");
    modem_status <= 8'h00;
    rd_chk(`RA_MODEM, 8'h00, "modem");
    wait_irq(1'b0, 3);
    {enh_en, auto_cts_en} <= 2'h3;
    u_host.bus_write(`RA_MASK, 8'ha0);
    cts_n_pin <= 1'b1;
    wait_irq(1'b1, 6);
    rd_chk(`RA_SRC, {2'b11, `CODE_FLOW}, "source");
    rd_chk(`RA_MODEM, 8'h00, "modem");
    wait_irq(1'b0, 3);
    pulse(1);
    wait_irq(1'b1, 3);
    rd_chk(`RA_SRC, {2'b11, `CODE_CHAR}, "source");
    wait_irq(1'b0, 3);
    u_host.bus_write(`RA_MASK, 8'h10);
    cyc(1);
    chk1("sleep_en", 1'b1, sleep_en);
    enh_en <= 1'b0;
    cyc(2);
    chk1("sleep_en", 1'b0, sleep_en);
    u_host.bus_write(`RA_MASK, 8'h01);
    rx_count <= 6'd2;
    bit_tick <= 1'b1;
    pulse(2);
    cyc(40);
    chk1("irq", 1'b0, irq);
    wait_irq(1'b1, 30);
    rd_chk(`RA_SRC, {2'b11, `CODE_TMO}, "source");
    rd_chk(`RA_HOLD, 8'h5a, "hold");
    wait_irq(1'b0, 3);
    u_host.bus_write(`RA_MASK, 8'h02);
    wait_irq(1'b1, 3);
    u_host.bus_write(`RA_HOLD, 8'h33);
    wait_irq(1'b0, 3);
    tx_count <= 6'd20;
    cyc(3);
    chk1("irq", 1'b0, irq);
    tx_count <= 6'd15;
    wait_irq(1'b1, 3);
    rd_chk(`RA_SRC, {2'b11, `CODE_TX}, "source");
    wait_irq(1'b0, 3);
    u_host.bus_write(`RA_MASK, 8'h04);
    pulse(3);
    wait_irq(1'b1, 3);
    rd_chk(`RA_LINE, 8'h61, "line");
    wait_irq(1'b0, 3);
    err_on_entry <= 1'b1;
    pulse(3);
    cyc(2);
    chk1("irq", 1'b0, irq);
    pulse(4);
    wait_irq(1'b1, 3);
    rd_chk(`RA_LINE, 8'h61, "line");
    wait_irq(1'b0, 3);
    enh_en <= 1'b1;
    auto_rts_en <= 1'b1;
    u_host.fifo_write(8'h09);
    u_host.bus_write(`RA_MASK, 8'h40);
    pulse(5);
    wait_irq(1'b1, 3);
    rd_chk(`RA_SRC, 8'hc1, "source");
    wait_irq(1'b0, 3);
    rts_n_out <= 1'b0;
    cyc(2);
    rts_n_out <= 1'b1;
    wait_irq(1'b1, 3);
    rd_chk(`RA_SRC, {2'b11, `CODE_FLOW}, "source");
    rd_chk(`RA_MODEM, 8'h00, "modem");
    wait_irq(1'b0, 3);
    final_report();
  end
endmodule : test_uart_interrupt_fifo_control
